// file: hbm_hash_engine.v
// Purpose: hash engine top: AHB-Lite register slave, block buffer, fetch master, core
// Assumes: one clock mclk, synchronous active-high reset
// Notes: every register transfer takes one wait state; input writes stall while the buffer is full or a fetch run is active
//
// The AHB-Lite slave port and the register offsets were decided locally.
`timescale 1ns/1ps
`include "hbm_consts.vh"

module hbm_hash_engine (
  input wire mclk,
  input wire reset,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg hreadyout,
  output reg hresp,
  output reg [31:0] hrdata,
  output wire [31:0] mHaddr,
  output wire [1:0] mHtrans,
  output wire mHwrite,
  output wire [2:0] mHsize,
  input wire mHready,
  input wire [31:0] mHrdata,
  input wire mHresp,
  output reg digestReady
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  reg dp;
  reg dpWrite;
  reg dpMapped;
  reg [3:0] dpIdx;
  reg useSha256;
  reg pendingFresh;
  reg [31:0] startAddr;
  reg [11:0] fetchCount;
  reg fetchStart;
  reg [31:0] blk [0:15];
  reg [3:0] wordIdx;
  reg bufFull;
  reg coreStart;
  reg coreFresh;
  reg [31:0] readMux;

  wire [511:0] blockBus;
  wire coreBusy;
  wire coreDone;
  wire [255:0] coreDigest;
  wire fetchValid;
  wire [31:0] fetchWord;
  wire fetchActive;
  wire fetchErr;
  wire runBusy;
  wire inWrite;
  wire ctrlWrite;
  wire fcWrite;
  wire stall;
  wire wordWrite;
  wire [31:0] wordData;
  wire [11:0] clampedCount;
  wire [7:0] digSel;
  wire setReady;
  wire clrReady;

  // ----------------------------------------
  // bus slave decode
  // ----------------------------------------
  assign runBusy = fetchStart | fetchActive;
  // the port stalls while a master run is busy, but a stalled word completes with the run's last fetched word and is not stored
  assign stall = dpWrite && dpMapped && (dpIdx == `HBM_IDX_INPUT) && (bufFull || runBusy);
  assign inWrite = dp && !stall && dpWrite && dpMapped && (dpIdx == `HBM_IDX_INPUT);
  assign ctrlWrite = dp && dpWrite && dpMapped && (dpIdx == `HBM_IDX_CTRL);
  assign fcWrite = dp && dpWrite && dpMapped && (dpIdx == `HBM_IDX_FETCH_CTRL);
  assign digSel = {~dpIdx[2:0], 5'h00};

  always @* begin
    readMux = 32'h0;
    if (dpMapped) begin
      if (dpIdx[`HBM_IDX_DIGEST_BIT]) begin
        readMux = coreDigest[digSel +: 32];
      end else begin
        case (dpIdx)
          `HBM_IDX_CTRL: readMux = {30'h0, useSha256, pendingFresh};
          `HBM_IDX_STATUS: readMux = {28'h0, fetchErr, runBusy,
            coreBusy | coreStart | bufFull, digestReady};
          `HBM_IDX_START_ADDR: readMux = startAddr;
          `HBM_IDX_FETCH_CTRL: readMux = {20'h0, fetchCount};
          default: readMux = 32'h0;
        endcase
      end
    end
  end

  always @(posedge mclk) begin
    if (reset) begin
      dp <= 1'b0;
      dpWrite <= 1'b0;
      dpMapped <= 1'b0;
      dpIdx <= 4'h0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h0;
    end else begin
      if (!dp && hsel && htrans[1] && hready) begin
        // address phase taken; answer after one wait state
        dp <= 1'b1;
        dpWrite <= hwrite;
        dpMapped <= (haddr[31:6] == 26'h0);
        dpIdx <= haddr[5:2];
        hreadyout <= 1'b0;
      end else if (dp && !stall) begin
        dp <= 1'b0;
        hreadyout <= 1'b1;
        hrdata <= dpWrite ? 32'h0 : readMux;
      end
    end
  end

  // ----------------------------------------
  // control and address registers
  // ----------------------------------------
  // a count above the 128 K byte window is cut down to it
  assign clampedCount = (hwdata[11:0] > `HBM_MAX_BLOCKS) ? `HBM_MAX_BLOCKS
    : hwdata[11:0];

  always @(posedge mclk) begin
    if (reset) begin
      useSha256 <= |(`HBM_CTRL_RESET & 2'h2);
      pendingFresh <= 1'b0;
      startAddr <= 32'h0;
      fetchCount <= 12'h0;
      fetchStart <= 1'b0;
    end else begin
      fetchStart <= 1'b0;
      if (coreStart) begin
        pendingFresh <= 1'b0;
      end
      if (ctrlWrite) begin
        useSha256 <= hwdata[`HBM_CTRL_SHA256];
        if (hwdata[`HBM_CTRL_NEW]) begin
          pendingFresh <= 1'b1;
        end
      end
      if (dp && dpWrite && dpMapped && (dpIdx == `HBM_IDX_START_ADDR)) begin
        startAddr <= {hwdata[31:2], 2'h0};
      end
      if (fcWrite && !runBusy) begin
        fetchCount <= clampedCount;
        fetchStart <= (clampedCount != 12'h0);
      end
    end
  end

  // ----------------------------------------
  // 16-word block buffer
  // ----------------------------------------
  assign wordWrite = inWrite | fetchValid;
  assign wordData = fetchValid ? fetchWord : hwdata;

  genvar i;
  generate
    for (i = 0; i < 16; i = i + 1) begin : flat
      assign blockBus[511 - 32 * i -: 32] = blk[i];
      always @(posedge mclk) begin
        if (wordWrite && (wordIdx == i)) begin
          blk[i] <= wordData;
        end
      end
    end
  endgenerate

  always @(posedge mclk) begin
    if (reset) begin
      wordIdx <= 4'h0;
      bufFull <= 1'b0;
      coreStart <= 1'b0;
      coreFresh <= 1'b0;
    end else begin
      coreStart <= 1'b0;
      if (ctrlWrite && hwdata[`HBM_CTRL_NEW]) begin
        // a new hash drops any half-written block
        wordIdx <= 4'h0;
      end else if (wordWrite) begin
        wordIdx <= wordIdx + 4'h1;
        if (wordIdx == `HBM_WORDS_PER_BLOCK) begin
          bufFull <= 1'b1;
        end
      end
      if (bufFull && !coreBusy && !coreStart) begin
        bufFull <= 1'b0;
        coreStart <= 1'b1;
        coreFresh <= pendingFresh;
      end
    end
  end

  // ----------------------------------------
  // digest-ready flag
  // ----------------------------------------
  // only set when nothing else is queued, so a run started in time keeps it low
  assign setReady = coreDone && !bufFull && !coreStart && (wordIdx == 4'h0)
    && !runBusy;
  // master words never clear it, so a continuation run keeps it set
  assign clrReady = (inWrite && (wordIdx == 4'h0))
    || (ctrlWrite && hwdata[`HBM_CTRL_NEW]);

  always @(posedge mclk) begin
    if (reset) begin
      digestReady <= 1'b0;
    end else if (setReady) begin
      digestReady <= 1'b1;
    end else if (clrReady) begin
      digestReady <= 1'b0;
    end
  end

  // ----------------------------------------
  // submodules
  // ----------------------------------------
  hbm_sha_core core (
    .mclk(mclk),
    .reset(reset),
    .start(coreStart),
    .fresh(coreFresh),
    .useSha256(useSha256),
    .block(blockBus),
    .busy(coreBusy),
    .done(coreDone),
    .digest(coreDigest)
  );

  // the fetch run continues the chain unless software asked for a new hash
  hbm_fetch fetch (
    .mclk(mclk),
    .reset(reset),
    .start(fetchStart),
    .startAddr(startAddr),
    .blockCount(fetchCount),
    .room(!bufFull),
    .mHaddr(mHaddr),
    .mHtrans(mHtrans),
    .mHwrite(mHwrite),
    .mHsize(mHsize),
    .mHready(mHready),
    .mHrdata(mHrdata),
    .mHresp(mHresp),
    .wordValid(fetchValid),
    .wordData(fetchWord),
    .active(fetchActive),
    .busErr(fetchErr)
  );
endmodule

// file: hbm_consts.vh
// Purpose: shared constants of the bus-mastering hash engine
// Assumes: included by its bare name from every design file
// Notes: register offsets are word indices; the slave's byte address is index * 4
`ifndef HBM_CONSTS_VH
`define HBM_CONSTS_VH

// ----------------------------------------
// register word indices (byte address = index * 4)
// ----------------------------------------
`define HBM_IDX_CTRL 4'h0
`define HBM_IDX_STATUS 4'h1
`define HBM_IDX_INPUT 4'h2
`define HBM_IDX_START_ADDR 4'h3
`define HBM_IDX_FETCH_CTRL 4'h4
`define HBM_IDX_DIGEST_BIT 3
// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define HBM_CTRL_NEW 0
`define HBM_CTRL_SHA256 1
`define HBM_CTRL_RESET 2'h0
`define HBM_ST_READY 0
`define HBM_ST_BUSY 1
`define HBM_ST_FETCH 2
`define HBM_ST_BUSERR 3
`define HBM_FC_COUNT_W 12
`define HBM_MAX_BLOCKS 12'h800
`define HBM_WORDS_PER_BLOCK 4'hF
// ----------------------------------------
// bus encodings
// ----------------------------------------
`define HBM_HTRANS_IDLE 2'h0
`define HBM_HTRANS_NONSEQ 2'h2
`define HBM_HSIZE_WORD 3'h2
// ----------------------------------------
// hash constants
// ----------------------------------------
`define HBM_SHA256_LAST 7'h3F
`define HBM_SHA1_LAST 7'h4F
`define HBM_IV256 {32'h6A09E667, 32'hBB67AE85, 32'h3C6EF372, 32'hA54FF53A, \
  32'h510E527F, 32'h9B05688C, 32'h1F83D9AB, 32'h5BE0CD19}
`define HBM_IV1 {32'h67452301, 32'hEFCDAB89, 32'h98BADCFE, 32'h10325476, \
  32'hC3D2E1F0, 96'h0}
`define HBM_K1_0 32'h5A827999
`define HBM_K1_1 32'h6ED9EBA1
`define HBM_K1_2 32'h8F1BBCDC
`define HBM_K1_3 32'hCA62C1D6

`endif

// file: hbm_sha_core.v
// Purpose: one-round-per-cycle SHA-1 / SHA-256 compression of one block
// Assumes: block held stable in the cycle start is high
// Notes: digest words are big-endian H0 first; SHA-1 leaves H5..H7 zero
`timescale 1ns/1ps
`include "hbm_consts.vh"
module hbm_sha_core (
  input wire mclk,
  input wire reset,
  input wire start,
  input wire fresh,
  input wire useSha256,
  input wire [511:0] block,
  output reg busy,
  output reg done,
  output reg [255:0] digest
);
  localparam [2047:0] K256 = {
    32'h428A2F98, 32'h71374491, 32'hB5C0FBCF, 32'hE9B5DBA5, 32'h3956C25B, 32'h59F111F1,
    32'h923F82A4, 32'hAB1C5ED5, 32'hD807AA98, 32'h12835B01, 32'h243185BE, 32'h550C7DC3,
    32'h72BE5D74, 32'h80DEB1FE, 32'h9BDC06A7, 32'hC19BF174, 32'hE49B69C1, 32'hEFBE4786,
    32'h0FC19DC6, 32'h240CA1CC, 32'h2DE92C6F, 32'h4A7484AA, 32'h5CB0A9DC, 32'h76F988DA,
    32'h983E5152, 32'hA831C66D, 32'hB00327C8, 32'hBF597FC7, 32'hC6E00BF3, 32'hD5A79147,
    32'h06CA6351, 32'h14292967, 32'h27B70A85, 32'h2E1B2138, 32'h4D2C6DFC, 32'h53380D13,
    32'h650A7354, 32'h766A0ABB, 32'h81C2C92E, 32'h92722C85, 32'hA2BFE8A1, 32'hA81A664B,
    32'hC24B8B70, 32'hC76C51A3, 32'hD192E819, 32'hD6990624, 32'hF40E3585, 32'h106AA070,
    32'h19A4C116, 32'h1E376C08, 32'h2748774C, 32'h34B0BCB5, 32'h391C0CB3, 32'h4ED8AA4A,
    32'h5B9CCA4F, 32'h682E6FF3, 32'h748F82EE, 32'h78A5636F, 32'h84C87814, 32'h8CC70208,
    32'h90BEFFFA, 32'hA4506CEB, 32'hBEF9A3F7, 32'hC67178F2};

  function [31:0] rotr(input [31:0] x, input [4:0] n);
    rotr = (x >> n) | (x << (6'h20 - {1'b0, n}));
  endfunction

  reg [31:0] w [0:15];
  reg [31:0] a, b, c, d, e, f, g, h;
  reg [6:0] round;
  reg mode;
  reg finish;
  wire [31:0] newW256;
  wire [31:0] newW1;
  wire [10:0] kIdx;
  wire [31:0] t1;
  wire [31:0] t2;
  reg [31:0] f1;
  reg [31:0] k1;
  wire [31:0] tmp1;
  wire [255:0] base;

  // ----------------------------------------
  // message schedule as a sliding 16-word window
  // ----------------------------------------
  assign newW256 = (rotr(w[14], 5'h11) ^ rotr(w[14], 5'h13) ^ (w[14] >> 10)) + w[9]
    + (rotr(w[1], 5'h07) ^ rotr(w[1], 5'h12) ^ (w[1] >> 3)) + w[0];
  assign newW1 = rotr(w[13] ^ w[8] ^ w[2] ^ w[0], 5'h1F);

  genvar i;
  generate
    for (i = 0; i < 16; i = i + 1) begin : sched
      always @(posedge mclk) begin
        if (start) begin
          w[i] <= block[511 - 32 * i -: 32];
        end else if (busy) begin
          if (i == 15) begin
            w[i] <= mode ? newW256 : newW1;
          end else begin
            w[i] <= w[(i + 1) % 16];
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // round functions
  // ----------------------------------------
  assign kIdx = {~round[5:0], 5'h00};
  assign t1 = h + (rotr(e, 5'h06) ^ rotr(e, 5'h0B) ^ rotr(e, 5'h19))
    + ((e & f) ^ (~e & g)) + K256[kIdx +: 32] + w[0];
  assign t2 = (rotr(a, 5'h02) ^ rotr(a, 5'h0D) ^ rotr(a, 5'h16))
    + ((a & b) ^ (a & c) ^ (b & c));

  always @* begin
    if (round < 7'h14) begin
      f1 = (b & c) | (~b & d);
      k1 = `HBM_K1_0;
    end else if (round < 7'h28) begin
      f1 = b ^ c ^ d;
      k1 = `HBM_K1_1;
    end else if (round < 7'h3C) begin
      f1 = (b & c) | (b & d) | (c & d);
      k1 = `HBM_K1_2;
    end else begin
      f1 = b ^ c ^ d;
      k1 = `HBM_K1_3;
    end
  end
  assign tmp1 = rotr(a, 5'h1B) + f1 + e + k1 + w[0];

  // fresh blocks start from the algorithm's IV, others chain on the digest
  assign base = fresh ? (useSha256 ? `HBM_IV256 : `HBM_IV1) : digest;

  always @(posedge mclk) begin
    if (reset) begin
      busy <= 1'b0;
      done <= 1'b0;
      finish <= 1'b0;
      round <= 7'h00;
      mode <= 1'b0;
      digest <= 256'h0;
    end else begin
      done <= 1'b0;
      finish <= 1'b0;
      if (start) begin
        mode <= useSha256;
        digest <= base;
        {a, b, c, d, e, f, g, h} <= base;
        round <= 7'h00;
        busy <= 1'b1;
      end else if (busy) begin
        if (mode) begin
          {a, b, c, d, e, f, g, h} <= {t1 + t2, a, b, c, d + t1, e, f, g};
        end else begin
          {a, b, c, d, e} <= {tmp1, a, rotr(b, 5'h02), c, d};
        end
        round <= round + 7'h01;
        if (round == (mode ? `HBM_SHA256_LAST : `HBM_SHA1_LAST)) begin
          busy <= 1'b0;
          finish <= 1'b1;
        end
      end else if (finish) begin
        digest[255:96] <= {digest[255:224] + a, digest[223:192] + b,
          digest[191:160] + c, digest[159:128] + d, digest[127:96] + e};
        if (mode) begin
          digest[95:0] <= {digest[95:64] + f, digest[63:32] + g, digest[31:0] + h};
        end
        done <= 1'b1;
      end
    end
  end
endmodule

// file: hbm_fetch.v
// Purpose: AHB-Lite read master that streams memory words to the engine
// Assumes: single non-pipelined word reads; room refreshes one cycle after a word
// Notes: an error response ends the run and raises busErr
`timescale 1ns/1ps
`include "hbm_consts.vh"
module hbm_fetch (
  input wire mclk,
  input wire reset,
  input wire start,
  input wire [31:0] startAddr,
  input wire [11:0] blockCount,
  input wire room,
  output reg [31:0] mHaddr,
  output reg [1:0] mHtrans,
  output reg mHwrite,
  output reg [2:0] mHsize,
  input wire mHready,
  input wire [31:0] mHrdata,
  input wire mHresp,
  output reg wordValid,
  output reg [31:0] wordData,
  output reg active,
  output reg busErr
);
  localparam ST_IDLE = 3'h1;
  localparam ST_ADDR = 3'h2;
  localparam ST_DATA = 3'h4;

  reg [2:0] state;
  reg [15:0] wordsLeft;

  always @(posedge mclk) begin
    if (reset) begin
      state <= ST_IDLE;
      mHaddr <= 32'h0;
      mHtrans <= `HBM_HTRANS_IDLE;
      mHwrite <= 1'b0;
      mHsize <= `HBM_HSIZE_WORD;
      wordValid <= 1'b0;
      wordData <= 32'h0;
      active <= 1'b0;
      busErr <= 1'b0;
      wordsLeft <= 16'h0;
    end else begin
      wordValid <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (start && !active) begin
            active <= 1'b1;
            busErr <= 1'b0;
            mHaddr <= startAddr;
            wordsLeft <= {blockCount, 4'h0};
          end else if (active && room && !wordValid) begin
            // no processor help: the master keeps the buffer fed
            mHtrans <= `HBM_HTRANS_NONSEQ;
            state <= ST_ADDR;
          end
        end
        ST_ADDR: begin
          if (mHready) begin
            mHtrans <= `HBM_HTRANS_IDLE;
            state <= ST_DATA;
          end
        end
        ST_DATA: begin
          if (mHready) begin
            state <= ST_IDLE;
            if (mHresp) begin
              active <= 1'b0;
              busErr <= 1'b1;
            end else begin
              wordValid <= 1'b1;
              wordData <= mHrdata;
              mHaddr <= mHaddr + 32'h4;
              wordsLeft <= wordsLeft - 16'h1;
              if (wordsLeft == 16'h1) begin
                active <= 1'b0;
              end
            end
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end
endmodule

// file: hbm_hash_asserts.sv
// Purpose: port checker of the hash engine
// Assumes: bus hready tied to hreadyout, one clock
// Notes: helper state tracks input-port block position and quiet cycles
`timescale 1ns/1ps
`include "hbm_consts.vh"
module hbm_hash_asserts (
  input logic mclk,
  input logic reset,
  input logic hsel,
  input logic [31:0] haddr,
  input logic [1:0] htrans,
  input logic hwrite,
  input logic [31:0] hwdata,
  input logic hready,
  input logic hreadyout,
  input logic hresp,
  input logic [31:0] mHaddr,
  input logic [1:0] mHtrans,
  input logic mHwrite,
  input logic [2:0] mHsize,
  input logic mHready,
  input logic digestReady
);
  logic phW;
  logic mDp;
  logic [3:0] phIdx;
  logic [3:0] inCnt;
  logic [7:0] quiet;
  wire taken = hsel && htrans[1] && hready && hreadyout;
  wire wrDone = phW && hreadyout;
  wire inDone = wrDone && phIdx == `HBM_IDX_INPUT;
  wire newDone = wrDone && phIdx == `HBM_IDX_CTRL && hwdata[`HBM_CTRL_NEW];
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  // ----------------------------------------
  // helper state
  // ----------------------------------------
  always @(posedge mclk) begin
    if (reset) begin
      phW <= 1'b0;
      mDp <= 1'b0;
      inCnt <= 4'h0;
      quiet <= 8'h0;
    end else begin
      if (taken) begin
        phW <= hwrite && haddr[31:6] == 26'h0;
        phIdx <= haddr[5:2];
      end else if (hreadyout) begin
        phW <= 1'b0;
      end
      if (mHready) begin
        mDp <= mHtrans[1];
      end
      if (inDone) begin
        inCnt <= inCnt + 4'h1;
      end
      if (newDone) begin
        inCnt <= 4'h0;
      end
      // saturate so a long idle never wraps into a false short gap
      if (inDone || (mDp && mHready)) begin
        quiet <= 8'h0;
      end else if (quiet != 8'hFF) begin
        quiet <= quiet + 8'h1;
      end
    end
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  sequence sTaken;
    taken;
  endsequence
  sequence sOneWait;
    !hreadyout ##1 hreadyout;
  endsequence
  AST_RESET_IDLE: assert property (disable iff (1'b0) $fell(reset) |-> hreadyout && !digestReady
    && mHtrans == `HBM_HTRANS_IDLE) else $error("outputs not idle after reset");
  AST_OKAY: assert property (hresp == 1'b0) else $error("slave answered an error");
  AST_ONE_WAIT: assert property (sTaken ##0 !(hwrite && haddr[5:2] == `HBM_IDX_INPUT)
    |=> sOneWait) else $error("register access not one wait state");
  AST_STALL_END: assert property (!hreadyout |-> ##[1:1000] hreadyout)
    else $error("register stall never ends");
  AST_FIRST_WORD_CLR: assert property (inDone && inCnt == 4'h0 |=> !digestReady)
    else $error("first input word left digest ready set");
  AST_FETCH_KEEP: assert property (digestReady && mDp && mHready |=> digestReady)
    else $error("fetched word cleared digest ready");
  AST_READY_AFTER_CORE: assert property ($rose(digestReady) |-> quiet >= 8'h40)
    else $error("digest ready before the core could finish");
  AST_NO_READY_PARTIAL: assert property (inCnt != 4'h0 |-> !$rose(digestReady))
    else $error("digest ready with a partial block");
  AST_MASTER_HOLD: assert property ((mHtrans[1] || mDp) && !mHready |=>
    $stable(mHaddr) && $stable(mHtrans)) else $error("master changed a held transfer");
  AST_MASTER_READ: assert property (!mHwrite && mHsize == `HBM_HSIZE_WORD)
    else $error("master not a word reader");
endmodule
bind hbm_hash_engine hbm_hash_asserts hbm_hash_asserts_i (.mclk(mclk), .reset(reset),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .mHaddr(mHaddr), .mHtrans(mHtrans),
  .mHwrite(mHwrite), .mHsize(mHsize), .mHready(mHready), .digestReady(digestReady));

// file: hbm_mem_model.sv
// Purpose: memory slave answering the engine's fetch master
// Assumes: single word reads, optional three wait states
// Notes: every block is the padded three-letter message, so digests are known
`timescale 1ns/1ps
module hbm_mem_model (
  input logic mclk,
  input logic reset,
  input logic slow,
  input logic [31:0] mHaddr,
  input logic [1:0] mHtrans,
  output logic mHready,
  output logic [31:0] mHrdata,
  output logic mHresp,
  output logic [15:0] readCount,
  output logic [31:0] lastAddr
);
  logic pend;
  logic [1:0] wt;
  logic [31:0] lastData;
  function automatic logic [31:0] word(input logic [3:0] i);
    word = (i == 4'h0) ? 32'h61626380 : (i == 4'hF) ? 32'h00000018 : 32'h0;
  endfunction
  assign mHready = !pend || wt == 2'h0;
  // outside a data phase the bus shows the inverse of the last word, never stale data
  assign mHrdata = (pend && wt == 2'h0) ? word(lastAddr[5:2]) : ~lastData;
  assign mHresp = 1'b0;
  always @(posedge mclk) begin
    if (reset) begin
      pend <= 1'b0;
      wt <= 2'h0;
      lastData <= 32'h0;
      readCount <= 16'h0;
    end else begin
      if (wt != 2'h0) begin
        wt <= wt - 2'h1;
      end
      if (pend && mHready) begin
        pend <= 1'b0;
        lastData <= mHrdata;
      end
      if (mHready && mHtrans[1]) begin
        pend <= 1'b1;
        wt <= slow ? 2'h3 : 2'h0;
        lastAddr <= mHaddr;
        readCount <= readCount + 16'h1;
      end
    end
  end
endmodule

// file: hbm_tb.sv
// Purpose: self-checking bench of the hash engine
// Assumes: bench is the only register master
// Notes: digests expected are those of the padded three-letter message
`timescale 1ns/1ps
`include "hbm_consts.vh"
module tb;
  localparam logic [31:0] ctrlA = 32'h00;
  localparam logic [31:0] statA = 32'h04;
  localparam logic [31:0] inA = 32'h08;
  localparam logic [31:0] startA = 32'h0C;
  localparam logic [31:0] fetchA = 32'h10;
  localparam logic [31:0] digA = 32'h20;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = `HBM_HTRANS_IDLE;
  logic hwrite = 1'b0;
  logic [2:0] hsize = `HBM_HSIZE_WORD;
  logic [31:0] hwdata = 32'h0;
  logic slow = 1'b0;
  logic [31:0] rdata;
  logic [15:0] base;
  wire hreadyout, hresp, mHwrite, mHready, mHresp, digestReady;
  wire [31:0] hrdata, mHaddr, mHrdata, lastAddr;
  wire [1:0] mHtrans;
  wire [2:0] mHsize;
  wire [15:0] readCount;
  int err_count = 0;
  int n_compared = 0;
  int cycles = 0;
  always #20 mclk = ~mclk;
  hbm_hash_engine hbm_hash_engine_i (.mclk(mclk), .reset(reset), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .mHaddr(mHaddr), .mHtrans(mHtrans),
    .mHwrite(mHwrite), .mHsize(mHsize), .mHready(mHready), .mHrdata(mHrdata), .mHresp(mHresp),
    .digestReady(digestReady));
  hbm_mem_model hbm_mem_model_i (.mclk(mclk), .reset(reset), .slow(slow), .mHaddr(mHaddr),
    .mHtrans(mHtrans), .mHready(mHready), .mHrdata(mHrdata), .mHresp(mHresp),
    .readCount(readCount), .lastAddr(lastAddr));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic busOp(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge mclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= `HBM_HTRANS_NONSEQ;
    hwrite <= w;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= `HBM_HTRANS_IDLE;
    hwdata <= d;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    rdata = hrdata;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    busOp(1'b1, a, d);
  endtask
  task automatic rd(input logic [31:0] a);
    busOp(1'b0, a, 32'h0);
  endtask
  task automatic sendBlock(input logic [31:0] w0, input logic [31:0] w15);
    int i;
    wr(inA, w0);
    for (i = 1; i < 15; i++) wr(inA, 32'h0);
    wr(inA, w15);
  endtask
  task automatic waitReady();
    int i;
    for (i = 0; i < 300 && digestReady !== 1'b1; i++) @(posedge mclk);
    #1;
    chk("digestReady set", 32'h1, {31'h0, digestReady});
  endtask
  // polls until no run and no core work is left
  task automatic waitIdle();
    int i;
    rdata = 32'h6;
    for (i = 0; i < 200 && (rdata & 32'h6) != 32'h0; i++) rd(statA);
    chk("status idle", 32'h0, rdata & 32'h6);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    chk("hreadyout", 32'h1, {31'h0, hreadyout});
    rd(statA);
    chk("status", 32'h0, rdata);
    wr(statA, 32'hF);
    rd(32'h40);
    chk("unmapped", 32'h0, rdata);
    rd(statA);
    chk("status ro", 32'h0, rdata);
  endtask
  task automatic t_sha1();
    wr(ctrlA, 32'h1);
    sendBlock(32'h61626380, 32'h18);
    waitReady();
    rd(digA);
    chk("sha1 h0", 32'hA9993E36, rdata);
    rd(digA + 32'h10);
    chk("sha1 h4", 32'h9CD0D89D, rdata);
  endtask
  task automatic t_sha256();
    wr(ctrlA, 32'h3);
    sendBlock(32'h61626380, 32'h18);
    waitReady();
    rd(digA);
    chk("sha256 h0", 32'hBA7816BF, rdata);
    rd(digA + 32'h1C);
    chk("sha256 h7", 32'hF20015AD, rdata);
  endtask
  task automatic t_port_then_fetch();
    int i;
    base = readCount;
    wr(inA, 32'h80000000);
    #1;
    chk("cleared on first word", 32'h0, {31'h0, digestReady});
    for (i = 1; i < 16; i++) wr(inA, 32'h0);
    wr(startA, 32'h2000);
    wr(fetchA, 32'h1);
    rd(statA);
    chk("ready low after prompt start", 32'h0, rdata & 32'h1);
    waitIdle();
    waitReady();
    chk("reads", {16'h0, base + 16'h10}, {16'h0, readCount});
    chk("last addr", 32'h203C, lastAddr);
  endtask
  task automatic t_fetch_new();
    @(posedge mclk);
    slow <= 1'b1;
    base = readCount;
    wr(ctrlA, 32'h3);
    wr(startA, 32'h1002);
    wr(fetchA, 32'h1);
    waitIdle();
    waitReady();
    rd(digA);
    chk("fetched h0", 32'hBA7816BF, rdata);
    chk("last addr", 32'h103C, lastAddr);
    chk("reads", {16'h0, base + 16'h10}, {16'h0, readCount});
  endtask
  task automatic t_fetch_continue();
    int i;
    @(posedge mclk);
    slow <= 1'b0;
    base = readCount;
    wr(fetchA, 32'h0);
    repeat (8) @(posedge mclk);
    chk("zero count idle", {16'h0, base}, {16'h0, readCount});
    wr(startA, 32'h3000);
    wr(fetchA, 32'h2);
    for (i = 0; i < 50 && mHtrans !== `HBM_HTRANS_NONSEQ; i++) @(posedge mclk);
    #1;
    chk("ready kept in run", 32'h1, {31'h0, digestReady});
    // a count written while the run is active must be ignored
    wr(fetchA, 32'h5);
    waitIdle();
    chk("ready kept after run", 32'h1, {31'h0, digestReady});
    rd(fetchA);
    chk("count kept", 32'h2, rdata);
    chk("reads", {16'h0, base + 16'h20}, {16'h0, readCount});
    chk("last addr", 32'h307C, lastAddr);
    sendBlock(32'h80000000, 32'h00000C00);
    waitReady();
  endtask
  // ----------------------------------------
  // run control
  // ----------------------------------------
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      finish_test();
    end
  end
  initial begin
    repeat (6) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    #1;
    t_reset();
    t_sha1();
    t_sha256();
    t_port_then_fetch();
    t_fetch_new();
    t_fetch_continue();
    finish_test();
  end
endmodule
